// >>> hw/mre_exec.sv
/*
 * Execution unit for the move, load-literal, no-operation and return group
 * of an 8-bit core. Holds the working register, program counter and global
 * interrupt enable. Assumes the stack, file registers and interrupt
 * controller live outside on the same clock and answer combinationally.
 */
`timescale 1ns/1ps
`include "mre_params.svh"

module mre_exec
  import mre_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Instruction issue
  input wire logic i_insn_valid,
  input wire logic [`MRE_INSN_W-1:0] i_insn,
  output logic o_ready,
  output logic o_foreign,
  // Stack
  input wire logic [`MRE_PC_W-1:0] i_stack_top,
  output logic o_stack_pop,
  // Interrupt controller clears the enable on interrupt entry
  input wire logic i_gie_clr,
  output logic [`MRE_DATA_W-1:0] o_irq_ctrl_gie,
  // Core state
  output logic [`MRE_PC_W-1:0] o_pc,
  output logic [`MRE_DATA_W-1:0] o_acc,
  output logic o_flag_we,
  // File register write port
  output mre_fwr_t o_fwr
);

  // ========================================================================
  // Declarations
  typedef enum logic {
    MRE_ST_RUN,
    MRE_ST_FLUSH
  } mre_state_t;

  mre_state_t state_ff, nxt_state;
  mre_dec_t dec;
  logic take;
  logic ready_ff, nxt_ready;
  logic foreign_ff, nxt_foreign;
  logic pop_ff, nxt_pop;
  logic gie_ff, nxt_gie;
  logic [`MRE_PC_W-1:0] pc_ff, nxt_pc;
  logic [`MRE_DATA_W-1:0] acc_ff, nxt_acc;
  mre_fwr_t fwr_ff, nxt_fwr;

  // ========================================================================
  // Decode
  mre_decode u_decode (
    .i_insn(i_insn),
    .o_dec(dec)
  );

  // An instruction is taken only while no return is being flushed
  assign take = i_insn_valid && ready_ff;

  // ========================================================================
  // Execute: next values
  always_comb begin
    nxt_state = MRE_ST_RUN;
    nxt_ready = 1'b1;
    nxt_foreign = 1'b0;
    nxt_pop = 1'b0;
    nxt_pc = pc_ff;
    nxt_acc = acc_ff;
    nxt_fwr = '0;
    nxt_fwr.addr = fwr_ff.addr;
    nxt_fwr.data = fwr_ff.data;
    // Interrupt entry clears the enable; a return from interrupt in the same cycle wins
    nxt_gie = i_gie_clr ? 1'b0 : gie_ff;
    if (take) begin
      unique case (dec.op)
        MRE_OP_STORE_ACC_TO_FILE: begin
          nxt_fwr.we = 1'b1;
          nxt_fwr.addr = dec.faddr;
          nxt_fwr.data = acc_ff;
          nxt_pc = pc_ff + `MRE_PC_W'(1);
        end
        MRE_OP_LOAD_LITERAL_TO_ACC: begin
          nxt_acc = dec.literal;
          nxt_pc = pc_ff + `MRE_PC_W'(1);
        end
        MRE_OP_NO_OPERATION: begin
          nxt_pc = pc_ff + `MRE_PC_W'(1);
        end
        MRE_OP_RETURN_FROM_IRQ: begin
          nxt_pop = 1'b1;
          nxt_pc = i_stack_top;
          nxt_gie = 1'b1;
          nxt_state = MRE_ST_FLUSH;
          nxt_ready = 1'b0;
        end
        MRE_OP_RETURN_WITH_LITERAL: begin
          nxt_acc = dec.literal;
          nxt_pop = 1'b1;
          nxt_pc = i_stack_top;
          nxt_state = MRE_ST_FLUSH;
          nxt_ready = 1'b0;
        end
        MRE_OP_RETURN_SUB: begin
          nxt_pop = 1'b1;
          nxt_pc = i_stack_top;
          nxt_state = MRE_ST_FLUSH;
          nxt_ready = 1'b0;
        end
        MRE_OP_OTHER: begin
          // Left to the rest of the core; this unit holds its state
          nxt_foreign = 1'b1;
        end
      endcase
    end
  end

  // ========================================================================
  // Execute: registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= MRE_ST_RUN;
      ready_ff <= 1'b1;
      foreign_ff <= 1'b0;
      pop_ff <= 1'b0;
      gie_ff <= `MRE_GIE_RST;
      pc_ff <= `MRE_PC_RST;
      acc_ff <= `MRE_ACC_RST;
      fwr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      foreign_ff <= nxt_foreign;
      pop_ff <= nxt_pop;
      gie_ff <= nxt_gie;
      pc_ff <= nxt_pc;
      acc_ff <= nxt_acc;
      fwr_ff <= nxt_fwr;
    end
  end

  // ========================================================================
  // Outputs, all from flip-flops except o_flag_we and the low seven bits of o_irq_ctrl_gie, which are tied low
  assign o_ready = ready_ff;
  assign o_foreign = foreign_ff;
  assign o_stack_pop = pop_ff;
  assign o_pc = pc_ff;
  assign o_acc = acc_ff;
  assign o_fwr = fwr_ff;
  // Only the enable bit of the control register belongs to this unit
  assign o_irq_ctrl_gie = {gie_ff, 7'h00};
  // No instruction of this group touches a status flag
  assign o_flag_we = 1'b0;

  // ========================================================================
  // Checks
  default clocking mre_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_take(mre_op_t o);
    i_insn_valid && ready_ff && dec.op == o;
  endsequence

  a_store_writes_file: assert property (
    s_take(MRE_OP_STORE_ACC_TO_FILE) |=> o_fwr.we && o_fwr.addr == $past(i_insn[6:0])
      && o_fwr.data == $past(acc_ff) && o_ready && o_flag_we == 1'b0)
    else $error("store did not write the accumulator to the file");

  a_load_sets_acc: assert property (
    s_take(MRE_OP_LOAD_LITERAL_TO_ACC) |=> o_acc == $past(i_insn[7:0])
      && o_pc == $past(pc_ff) + 13'h0001 && !o_stack_pop)
    else $error("literal load did not reach the accumulator");

  a_zero_dontcare_ok: assert property (
    i_insn_valid && (i_insn & 14'h3f00) == 14'h3000 |-> dec.op == MRE_OP_LOAD_LITERAL_TO_ACC)
    else $error("zeroed don't-care literal load not decoded");

  a_return_pops_two: assert property (
    s_take(MRE_OP_RETURN_FROM_IRQ) |=> o_stack_pop && o_pc == $past(i_stack_top)
      && !o_ready ##1 o_ready && !o_stack_pop)
    else $error("irq return did not pop and take two cycles");

  a_retirq_sets_gie: assert property (
    s_take(MRE_OP_RETURN_FROM_IRQ) |=> o_irq_ctrl_gie[7] == 1'b1)
    else $error("irq return did not set the enable");

  a_retlit_loads_both: assert property (
    s_take(MRE_OP_RETURN_WITH_LITERAL) |=> o_acc == $past(i_insn[7:0])
      && o_pc == $past(i_stack_top) && !o_ready ##1 o_ready)
    else $error("literal return lost the literal or the address");

  a_retsub_pops: assert property (
    s_take(MRE_OP_RETURN_SUB) |=> o_stack_pop && o_pc == $past(i_stack_top)
      && $stable(o_acc) && !o_ready ##1 o_ready)
    else $error("subroutine return misbehaved");

  a_nop_is_quiet: assert property (
    s_take(MRE_OP_NO_OPERATION) |=> $stable(o_acc) && !o_fwr.we && !o_stack_pop
      && o_pc == $past(pc_ff) + 13'h0001 && o_ready)
    else $error("no-operation changed state");

  c_store: cover property (s_take(MRE_OP_STORE_ACC_TO_FILE));
  // Return and interrupt-entry clear in one cycle: the set must win
  c_retirq_vs_clear: cover property (
    i_insn_valid && ready_ff && dec.op == MRE_OP_RETURN_FROM_IRQ && i_gie_clr);
  c_retlit: cover property (s_take(MRE_OP_RETURN_WITH_LITERAL));
  c_back_to_back: cover property (s_take(MRE_OP_RETURN_SUB) ##2 s_take(MRE_OP_NO_OPERATION));

endmodule

// >>> hw/mre_params.svh
/*
 * Constants of the move-and-return execution unit: opcode patterns,
 * field positions, reset values and instruction-cycle counts.
 * Assumes 14-bit instruction words and a 13-bit program counter.
 */
`ifndef MRE_PARAMS_SVH
`define MRE_PARAMS_SVH

// ==========================================================================
// Widths
`define MRE_INSN_W 14
`define MRE_PC_W 13
`define MRE_DATA_W 8
`define MRE_FADDR_W 7

// ==========================================================================
// Opcode patterns (mask, match; the two plain returns as whole words)
`define MRE_STORE_MASK 14'h3f80
`define MRE_STORE_MATCH 14'h0080
`define MRE_LOADLIT_MASK 14'h3c00
`define MRE_LOADLIT_MATCH 14'h3000
`define MRE_RETLIT_MASK 14'h3c00
`define MRE_RETLIT_MATCH 14'h3400
`define MRE_NOP_MASK 14'h3f9f
`define MRE_NOP_MATCH 14'h0000
`define MRE_RETIRQ_WORD 14'h0009
`define MRE_RETSUB_WORD 14'h0008

// ==========================================================================
// Field positions
`define MRE_LIT_LSB 0
`define MRE_FADDR_LSB 0
`define MRE_GIE_BIT 7

// ==========================================================================
// Reset values and cycle counts
`define MRE_PC_RST 13'h0000
`define MRE_ACC_RST 8'h00
`define MRE_GIE_RST 1'b0
`define MRE_SINGLE_CYCLES 1
`define MRE_RETURN_CYCLES 2

`endif

// >>> hw/mre_pkg.sv
/*
 * Types shared by the move-and-return execution unit.
 * Assumes mre_params.svh is on the include path.
 */
`include "mre_params.svh"

package mre_pkg;

  // ========================================================================
  // Decoded operation classes
  typedef enum logic [2:0] {
    MRE_OP_OTHER,
    MRE_OP_STORE_ACC_TO_FILE,
    MRE_OP_LOAD_LITERAL_TO_ACC,
    MRE_OP_NO_OPERATION,
    MRE_OP_RETURN_FROM_IRQ,
    MRE_OP_RETURN_WITH_LITERAL,
    MRE_OP_RETURN_SUB
  } mre_op_t;

  // Decoder result
  typedef struct packed {
    mre_op_t op;
    logic [`MRE_DATA_W-1:0] literal;
    logic [`MRE_FADDR_W-1:0] faddr;
  } mre_dec_t;

  // File register write port
  typedef struct packed {
    logic we;
    logic [`MRE_FADDR_W-1:0] addr;
    logic [`MRE_DATA_W-1:0] data;
  } mre_fwr_t;

endpackage

// >>> hw/mre_decode.sv
/*
 * Combinational decoder for the move and return instruction group.
 * Assumes a stable instruction word from the fetch stage on the same clock.
 */
`timescale 1ns/1ps
`include "mre_params.svh"

module mre_decode
  import mre_pkg::*;
(
  // Instruction word
  input wire logic [`MRE_INSN_W-1:0] i_insn,
  // Decoded result
  output mre_dec_t o_dec
);

  // ========================================================================
  // Pattern match
  function automatic logic hit(input logic [`MRE_INSN_W-1:0] w,
                               input logic [`MRE_INSN_W-1:0] m,
                               input logic [`MRE_INSN_W-1:0] v);
    hit = (w & m) == v;
  endfunction

  // First match wins; the patterns do not overlap
  always_comb begin
    o_dec.literal = i_insn[`MRE_LIT_LSB +: `MRE_DATA_W];
    o_dec.faddr = i_insn[`MRE_FADDR_LSB +: `MRE_FADDR_W];
    if (hit(i_insn, `MRE_STORE_MASK, `MRE_STORE_MATCH)) begin
      o_dec.op = MRE_OP_STORE_ACC_TO_FILE;
    end else if (hit(i_insn, `MRE_LOADLIT_MASK, `MRE_LOADLIT_MATCH)) begin
      // Don't-care bits written as zero fall outside the mask and still match
      o_dec.op = MRE_OP_LOAD_LITERAL_TO_ACC;
    end else if (hit(i_insn, `MRE_RETLIT_MASK, `MRE_RETLIT_MATCH)) begin
      o_dec.op = MRE_OP_RETURN_WITH_LITERAL;
    end else if (i_insn == `MRE_RETIRQ_WORD) begin
      o_dec.op = MRE_OP_RETURN_FROM_IRQ;
    end else if (i_insn == `MRE_RETSUB_WORD) begin
      o_dec.op = MRE_OP_RETURN_SUB;
    end else if (hit(i_insn, `MRE_NOP_MASK, `MRE_NOP_MATCH)) begin
      o_dec.op = MRE_OP_NO_OPERATION;
    end else begin
      o_dec.op = MRE_OP_OTHER;
    end
  end

endmodule

// >>> verification/tb_move_and_return_execution.sv
/*
 * Self-checking bench for the move-and-return execution unit.
 * Assumes mre_params.svh on the include path and a stack that answers
 * combinationally; the bench plays the stack and the interrupt controller.
 */
`timescale 1ns/1ps
`include "mre_params.svh"

module tb_move_and_return_execution;
  // ==========================================================================
  // Stimulus and observed signals
  logic clk;
  logic rst_b;
  logic insn_valid;
  logic [13:0] insn;
  logic [12:0] stack_top;
  logic gie_clr;
  logic ready;
  logic foreign;
  logic pop;
  logic [7:0] global_irq_enable;
  logic [12:0] pc;
  logic [7:0] acc;
  logic flag_we;
  logic [15:0] fwr;
  logic [12:0] epc;
  logic [7:0] eacc;
  logic [7:0] egie;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  mre_exec mre_exec_i (
    .i_clk(clk), .i_rst_b(rst_b), .i_insn_valid(insn_valid), .i_insn(insn),
    .o_ready(ready), .o_foreign(foreign), .i_stack_top(stack_top), .o_stack_pop(pop),
    .i_gie_clr(gie_clr), .o_irq_ctrl_gie(global_irq_enable), .o_pc(pc), .o_acc(acc),
    .o_flag_we(flag_we), .o_fwr(fwr)
  );

  // ==========================================================================
  // Clock and hang guard; the ceiling leaves ample room over the short run
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end

  // ==========================================================================
  // Shared helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Core state plus the outputs that must stay quiet on ordinary cycles
  task automatic core();
    chk("pc", {3'h0, epc}, {3'h0, pc});
    chk("acc", {8'h00, eacc}, {8'h00, acc});
    chk("gie", {8'h00, egie}, {8'h00, global_irq_enable});
    chk("flag_we", 16'h0000, {15'h0000, flag_we});
    chk("foreign", 16'h0000, {15'h0000, foreign});
  endtask

  // Called at a falling edge; returns at the next one, inside the answer cycle
  task automatic issue(input logic [13:0] w);
    insn_valid = 1'b1;
    insn = w;
    @(negedge clk);
  endtask

  task automatic idle();
    insn_valid = 1'b0;
    @(negedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_load();
    logic [13:0] words [4];
    words = '{14'h3000, 14'h30ff, 14'h335a, 14'h31a5};
    foreach (words[n]) begin
      issue(words[n]);
      epc = epc + 13'h0001;
      eacc = words[n][7:0];
      core();
    end
    idle();
  endtask

  task automatic t_store();
    issue(14'h00ff);
    epc = epc + 13'h0001;
    core();
    chk("fwr", {1'b1, 7'h7f, eacc}, fwr);
    issue(14'h0080);
    epc = epc + 13'h0001;
    core();
    chk("fwr", {1'b1, 7'h00, eacc}, fwr);
    idle();
    chk("fwr_we", 16'h0000, {15'h0000, fwr[15]});
  endtask

  task automatic t_nop();
    issue(14'h0000);
    epc = epc + 13'h0001;
    core();
    issue(14'h0060);
    epc = epc + 13'h0001;
    core();
    chk("fwr_we", 16'h0000, {15'h0000, fwr[15]});
    chk("pop", 16'h0000, {15'h0000, pop});
    idle();
  endtask

  // A word offered in the flushed slot must leave no trace
  task automatic t_return(input logic [13:0] w, input logic [12:0] top);
    stack_top = top;
    issue(w);
    stack_top = ~top;
    // The clear stands for the take cycle only, or it would undo the set
    gie_clr = 1'b0;
    epc = top;
    core();
    chk("pop", 16'h0001, {15'h0000, pop});
    chk("ready", 16'h0000, {15'h0000, ready});
    issue(14'h30ee);
    core();
    chk("pop", 16'h0000, {15'h0000, pop});
    chk("ready", 16'h0001, {15'h0000, ready});
    // The slot right after the flush must be taken again
    issue(14'h0000);
    epc = epc + 13'h0001;
    core();
    idle();
  endtask

  // A word outside the group pulses o_foreign and is not a no-operation
  task automatic t_foreign();
    issue(14'h0100);
    chk("foreign", 16'h0001, {15'h0000, foreign});
    chk("pc", {3'h0, epc}, {3'h0, pc});
    chk("acc", {8'h00, eacc}, {8'h00, acc});
    idle();
    core();
  endtask

  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    insn_valid = 1'b0;
    insn = 14'h0000;
    stack_top = 13'h0000;
    gie_clr = 1'b0;
    epc = 13'h0000;
    eacc = 8'h00;
    egie = 8'h00;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    core();
    chk("ready", 16'h0001, {15'h0000, ready});
    t_load();
    t_store();
    t_nop();
    t_foreign();
    // Clear held in the same cycle as the return: the set must win
    gie_clr = 1'b1;
    egie = 8'h80;
    t_return(14'h0009, 13'h1abc);
    gie_clr = 1'b0;
    eacc = 8'h3c;
    t_return(14'h343c, 13'h0001);
    eacc = 8'hc3;
    t_return(14'h37c3, 13'h1fff);
    t_return(14'h0008, 13'h0000);
    gie_clr = 1'b1;
    @(negedge clk);
    gie_clr = 1'b0;
    egie = 8'h00;
    core();
    finish_test();
  end
endmodule
